// ### logic/gbx_io_cell.sv
// Purpose: I/O cell pair with input delay, SDR/DDR/gearbox capture and APB control
// Assumes: All clocks other than core_clk_i arrive as levels sampled by core_clk_i
// Notes:   Capture edges are detected transitions of the sampled capture clock
// Functional notes
// R1: Cell holds two I/O blocks, each with output data, tristate and pad input.
// R2: Output block drives registered data and tristate enable to the pad.
// R3: Pad input also leaves unregistered as bypass, as clock, and as strobe input.
// R4: Input delay is fixed or dynamic from a 4-bit select.
// R5: Input register has exactly three modes: SDR, DDR and gearbox.
// R6: SDR mode captures the input in one system clock register.
// R7: DDR captures on rise and fall of strobe or edge clock.
// R8: DDR streams move into system clock registers as two parallel outputs.
// R9: Gearbox turns first block's DDR input into four parallel streams.
// R10: Gearbox data passes an edge stage, then the system stage.
// R11: Polarity input picks which capture edge loads the sync registers.
// R12: Latch input moves sync data into transfer and gearbox registers.
// R13: Strobe read control makes delayed strobe, polarity and latch signals.
// R14: Write leveling delay is an 8-bit setting with 128 steps.
// R15: Top bit of write leveling setting inverts the clock.
// R16: Edge clock divider by 2, 4, 8; low in hold, synchronous release.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module gbx_io_cell
   import gbx_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [1:0]  pad_in_data_i,
   input  wire logic [1:0]  core_out_data_i,
   input  wire logic [1:0]  core_tristate_i,
   output logic      [1:0]  pad_out_data_o,
   output logic      [1:0]  pad_tristate_ctl_o,
   output logic      [1:0]  comb_input_bypass_o,
   output logic      [1:0]  input_as_clock_o,
   output logic             strobe_delay_in_o,
   input  wire logic        edge_clk_i,
   input  wire logic        strobe_clk_i,
   input  wire logic        wl_clk_i,
   output logic             delayed_strobe_clk_o,
   output logic             sync_clk_polarity_o,
   output logic             sync_transfer_latch_o,
   output logic      [1:0]  sdr_data_o,
   output logic      [1:0]  ddr_pos_o,
   output logic      [1:0]  ddr_neg_o,
   output gbx_gear_t        gear_o,
   output logic             gear_valid_o,
   output logic             wl_clk_o,
   output logic             div_clk_o
);
   logic [31:0] ctrl;
   logic [31:0] dly;
   gbx_mode_t   mode;
   logic        generic_mode;
   logic [3:0]  input_delay_sel;
   logic [7:0]  write_level_delay;
   logic [3:0]  tap_sel;
   logic [1:0]  dly_q;
   logic [1:0]  din;
   logic        cap_clk;
   logic        cap_prev;
   logic        cap_rise;
   logic        cap_fall;
   logic        sync_evt;
   logic        sync_done;
   logic        phase;
   logic [1:0]  cap_pos;
   logic [1:0]  cap_neg;
   logic [1:0]  sync_pos;
   logic [1:0]  sync_neg;
   logic [1:0]  stage_a;
   logic [1:0]  stage_b;
   logic        wl_q;
   logic        wr_en;
   gbx_reg_t    wr_reg;
   gbx_reg_t    rd_reg;
   logic [31:0] stat;

   assign mode              = gbx_mode_t'(ctrl[GBX_CTRL_MODE_LSB +: 2]);    // [R5]
   assign generic_mode      = ctrl[GBX_CTRL_GENERIC];
   assign sync_clk_polarity_o = ctrl[GBX_CTRL_POL];                         // [R13]
   assign input_delay_sel   = dly[GBX_DLY_IN_LSB +: 4];
   assign write_level_delay = dly[GBX_DLY_WL_LSB +: 8];

   // APB slave: zero wait states, error on unmapped offsets
   assign pready_o  = 1'b1;
   assign wr_reg    = gbx_decode(paddr_i);
   assign rd_reg    = gbx_decode(paddr_i);
   assign wr_en     = psel_i & penable_i & pwrite_i;
   assign pslverr_o = psel_i & penable_i & (rd_reg == GBX_REG_NONE);

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl <= GBX_CTRL_RESET;
      end else if (wr_en && wr_reg == GBX_REG_CTRL) begin
         ctrl[31:2] <= {23'h0, pwdata_i[8:2]};
         // A reserved mode code leaves the mode unchanged
         if (pwdata_i[GBX_CTRL_MODE_LSB +: 2] != 2'h3) begin
            ctrl[GBX_CTRL_MODE_LSB +: 2] <= pwdata_i[GBX_CTRL_MODE_LSB +: 2];   // [R5]
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dly <= GBX_DELAY_RESET;
      end else if (wr_en && wr_reg == GBX_REG_DELAY) begin
         dly <= {16'h0, pwdata_i[15:8], 4'h0, pwdata_i[3:0]};
      end
   end

   assign stat = {19'h0, gear_o, ddr_neg_o, ddr_pos_o, sdr_data_o, phase, wl_clk_o, div_clk_o};

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_o <= 32'h0;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         case (rd_reg)
            GBX_REG_CTRL:  prdata_o <= ctrl;
            GBX_REG_DELAY: prdata_o <= dly;
            GBX_REG_STAT:  prdata_o <= stat;
            default:       prdata_o <= 32'h0;
         endcase
      end
   end

   // Pad transmit path, tristated while in reset
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pad_out_data_o     <= 2'h0;
         pad_tristate_ctl_o <= 2'h3;
      end else begin
         pad_out_data_o     <= core_out_data_i;                 // [R1] [R2]
         pad_tristate_ctl_o <= core_tristate_i;                 // [R1] [R2]
      end
   end

   assign comb_input_bypass_o = pad_in_data_i;                  // [R3]
   assign input_as_clock_o    = pad_in_data_i;                  // [R3]
   assign strobe_delay_in_o   = pad_in_data_i[0];               // [R3]

   assign tap_sel = ctrl[GBX_CTRL_DLY_DYN] ? input_delay_sel : GBX_FIXED_TAPS;   // [R4]

   for (genvar b = 0; b < 2; b++) begin : g_in_dly
      gbx_tap_delay #(
         .DEPTH (GBX_IN_TAPS)
      ) u_dly (
         .core_clk_i (core_clk_i),
         .resetn_i   (resetn_i),
         .d_i        (pad_in_data_i[b]),
         .sel_i      (tap_sel),
         .q_o        (dly_q[b])
      );
   end

   assign din = ctrl[GBX_CTRL_DLY_EN] ? dly_q : pad_in_data_i;  // [R4]

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sdr_data_o <= 2'h0;
      end else if (mode == GBX_MODE_SDR) begin
         sdr_data_o <= din;                                     // [R6]
      end
   end

   // Strobe read control: one stage of delay on the incoming strobe
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         delayed_strobe_clk_o <= 1'b0;
      end else begin
         delayed_strobe_clk_o <= strobe_clk_i;                  // [R13]
      end
   end

   assign cap_clk  = generic_mode ? edge_clk_i : delayed_strobe_clk_o;    // [R7]
   assign cap_rise = cap_clk & ~cap_prev;
   assign cap_fall = ~cap_clk & cap_prev;
   assign sync_evt = (mode == GBX_MODE_DDR || mode == GBX_MODE_GEAR)
                   & (sync_clk_polarity_o ? cap_rise : cap_fall);         // [R11]

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cap_prev <= 1'b0;
      end else begin
         cap_prev <= cap_clk;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cap_pos <= 2'h0;
         cap_neg <= 2'h0;
      end else if (mode == GBX_MODE_DDR || mode == GBX_MODE_GEAR) begin
         if (cap_rise) begin
            cap_pos <= din;                                     // [R7]
         end
         if (cap_fall) begin
            cap_neg <= din;                                     // [R7]
         end
      end
   end

   // Polarity low: pair closes on the falling edge, taking the live bit as negative data
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync_pos <= 2'h0;
         sync_neg <= 2'h0;
      end else if (sync_evt) begin
         sync_pos <= cap_pos;                                   // [R11]
         sync_neg <= sync_clk_polarity_o ? cap_neg : din;       // [R11]
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync_done <= 1'b0;
      end else begin
         sync_done <= sync_evt;
      end
   end

   // Latch every pair in DDR mode, every second pair in gearbox mode
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         phase                 <= 1'b0;
         sync_transfer_latch_o <= 1'b0;
      end else begin
         sync_transfer_latch_o <= sync_done & ((mode != GBX_MODE_GEAR) | phase);   // [R13]
         if (mode != GBX_MODE_GEAR) begin
            phase <= 1'b0;
         end else if (sync_done) begin
            phase <= ~phase;
         end
      end
   end

   // Edge stage of the gearbox, first block of the pair only
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stage_a <= 2'h0;
         stage_b <= 2'h0;
      end else if (sync_done && mode == GBX_MODE_GEAR) begin
         stage_a <= stage_b;                                    // [R10]
         stage_b <= {sync_neg[0], sync_pos[0]};                 // [R9] [R10]
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ddr_pos_o <= 2'h0;
         ddr_neg_o <= 2'h0;
      end else if (sync_transfer_latch_o && mode == GBX_MODE_DDR) begin
         ddr_pos_o <= sync_pos;                                 // [R8] [R12]
         ddr_neg_o <= sync_neg;                                 // [R8] [R12]
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gear_o       <= '0;
         gear_valid_o <= 1'b0;
      end else begin
         gear_valid_o <= sync_transfer_latch_o && mode == GBX_MODE_GEAR;
         if (sync_transfer_latch_o && mode == GBX_MODE_GEAR) begin
            gear_o <= {stage_b[1], stage_b[0], stage_a[1], stage_a[0]};   // [R9] [R12]
         end
      end
   end

   // Write leveling: 128-step delay, top bit inverts
   gbx_tap_delay #(
      .DEPTH (GBX_WL_TAPS)
   ) u_wl_dly (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .d_i        (wl_clk_i),
      .sel_i      (write_level_delay[6:0]),                     // [R14]
      .q_o        (wl_q)
   );

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wl_clk_o <= 1'b0;
      end else begin
         wl_clk_o <= wl_q ^ write_level_delay[7];               // [R15]
      end
   end

   gbx_clk_div u_div (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .src_i      (edge_clk_i),
      .div_sel_i  (gbx_div_t'(ctrl[GBX_CTRL_DIV_LSB +: 2])),
      .hold_i     (ctrl[GBX_CTRL_DIV_HOLD]),                    // [R16]
      .div_clk_o  (div_clk_o)
   );

   // Checks
   property p_pad_out;
      @(posedge core_clk_i) disable iff (!resetn_i)
      1'b1 |=> {pad_out_data_o, pad_tristate_ctl_o} == $past({core_out_data_i, core_tristate_i});
   endproperty
   a_pad_out: assert property (p_pad_out) else $error("pad output not registered"); // [R2]
   property p_sdr;
      @(posedge core_clk_i) disable iff (!resetn_i)
      mode == GBX_MODE_SDR |=> sdr_data_o == $past(din);
   endproperty
   a_sdr: assert property (p_sdr) else $error("sdr capture wrong"); // [R6]
   property p_ddr_rise;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (mode == GBX_MODE_DDR && cap_rise) |=> cap_pos == $past(din);
   endproperty
   a_ddr_rise: assert property (p_ddr_rise) else $error("rising capture wrong"); // [R7]
   property p_ddr_fall;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (mode == GBX_MODE_DDR && cap_fall) |=> cap_neg == $past(din);
   endproperty
   a_ddr_fall: assert property (p_ddr_fall) else $error("falling capture wrong"); // [R7]
   // Sync must follow a capture clock change towards the programmed polarity level
   property p_pol_edge;
      @(posedge core_clk_i) disable iff (!resetn_i)
      sync_done |-> $past(cap_clk) == $past(sync_clk_polarity_o)
                    && $past(cap_clk, 2) != $past(sync_clk_polarity_o);
   endproperty
   a_pol_edge: assert property (p_pol_edge) else $error("sync on wrong edge"); // [R11]
   property p_latch_xfer;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (sync_transfer_latch_o && mode == GBX_MODE_DDR && $stable(mode))
         |=> ddr_pos_o == $past(sync_pos) && ddr_neg_o == $past(sync_neg);
   endproperty
   a_latch_xfer: assert property (p_latch_xfer) else $error("latch transfer wrong"); // [R12]
   property p_gear_pair;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (sync_transfer_latch_o && mode == GBX_MODE_GEAR) |-> $past(sync_done) && $past(phase);
   endproperty
   a_gear_pair: assert property (p_gear_pair) else $error("gear latch off pair"); // [R9]
   property p_wl_inv;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (write_level_delay[6:0] == 7'h0 && $past(dly, 1) == dly && $past(dly, 2) == dly
         && $past(dly, 3) == dly) |-> wl_clk_o == ($past(wl_clk_i, 3) ^ write_level_delay[7]);
   endproperty
   a_wl_inv: assert property (p_wl_inv) else $error("write level clock wrong"); // [R15]
   property p_div_hold;
      @(posedge core_clk_i) disable iff (!resetn_i)
      ctrl[GBX_CTRL_DIV_HOLD] |=> !div_clk_o;
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divider not low in hold"); // [R16]

   property p_cov_gear;
      @(posedge core_clk_i) disable iff (!resetn_i) gear_valid_o;
   endproperty
   c_cov_gear: cover property (p_cov_gear);
   property p_cov_ddr;
      @(posedge core_clk_i) disable iff (!resetn_i)
      sync_transfer_latch_o && mode == GBX_MODE_DDR;
   endproperty
   c_cov_ddr: cover property (p_cov_ddr);
   property p_cov_div;
      @(posedge core_clk_i) disable iff (!resetn_i) !div_clk_o ##1 div_clk_o;
   endproperty
   c_cov_div: cover property (p_cov_div);
endmodule
`default_nettype wire

// ### logic/gbx_pkg.sv
// Purpose: Shared constants, types and decode for the input register gearbox cell
// Assumes: APB register map, 32-bit data, one word per register
// Notes:   Field positions are bit indices inside each register word
`default_nettype none
package gbx_pkg;
   localparam int unsigned GBX_AW            = 12;
   localparam logic [11:0] GBX_OFF_CTRL      = 12'h000;
   localparam logic [11:0] GBX_OFF_DELAY     = 12'h004;
   localparam logic [11:0] GBX_OFF_STAT      = 12'h008;
   localparam logic [31:0] GBX_CTRL_RESET    = 32'h0000_0000;
   localparam logic [31:0] GBX_DELAY_RESET   = 32'h0000_0000;
   // Control word fields
   localparam int unsigned GBX_CTRL_MODE_LSB = 0;
   localparam int unsigned GBX_CTRL_GENERIC  = 2;
   localparam int unsigned GBX_CTRL_DLY_EN   = 3;
   localparam int unsigned GBX_CTRL_DLY_DYN  = 4;
   localparam int unsigned GBX_CTRL_DIV_LSB  = 5;
   localparam int unsigned GBX_CTRL_DIV_HOLD = 7;
   localparam int unsigned GBX_CTRL_POL      = 8;
   // Delay word fields
   localparam int unsigned GBX_DLY_IN_LSB    = 0;
   localparam int unsigned GBX_DLY_WL_LSB    = 8;
   // Status word fields
   localparam int unsigned GBX_ST_DIV        = 0;
   localparam int unsigned GBX_ST_WL         = 1;
   localparam int unsigned GBX_ST_PHASE      = 2;
   localparam int unsigned GBX_ST_SDR_LSB    = 3;
   localparam int unsigned GBX_ST_POS_LSB    = 5;
   localparam int unsigned GBX_ST_NEG_LSB    = 7;
   localparam int unsigned GBX_ST_GEAR_LSB   = 9;
   // Tap counts
   localparam int unsigned GBX_IN_TAPS       = 16;
   localparam int unsigned GBX_WL_TAPS       = 128;
   localparam logic [3:0]  GBX_FIXED_TAPS    = 4'h8;

   typedef enum logic [1:0] {GBX_MODE_SDR, GBX_MODE_DDR, GBX_MODE_GEAR, GBX_MODE_RSVD} gbx_mode_t;
   typedef enum logic [1:0] {GBX_DIV2, GBX_DIV4, GBX_DIV8, GBX_DIV_RSVD} gbx_div_t;
   typedef enum logic [1:0] {GBX_REG_CTRL, GBX_REG_DELAY, GBX_REG_STAT, GBX_REG_NONE} gbx_reg_t;

   typedef struct packed {
      logic neg_b;
      logic pos_b;
      logic neg_a;
      logic pos_a;
   } gbx_gear_t;

   function automatic gbx_reg_t gbx_decode(input logic [11:0] addr);
      case (addr)
         GBX_OFF_CTRL:  return GBX_REG_CTRL;
         GBX_OFF_DELAY: return GBX_REG_DELAY;
         GBX_OFF_STAT:  return GBX_REG_STAT;
         default:       return GBX_REG_NONE;
      endcase
   endfunction
endpackage
`default_nettype wire

// ### logic/gbx_tap_delay.sv
// Purpose: Selectable tap delay line, one tap per system clock
// Assumes: Select stable while data passes through
// Notes:   Output is registered, so total delay is sel_i plus two cycles
`default_nettype none
module gbx_tap_delay
   import gbx_pkg::*;
#(
   parameter int unsigned DEPTH = 16,
   parameter int unsigned SW    = $clog2(DEPTH)
) (
   input  wire logic          core_clk_i,
   input  wire logic          resetn_i,
   input  wire logic          d_i,
   input  wire logic [SW-1:0] sel_i,
   output logic               q_o
);
   logic [DEPTH-1:0] taps;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         taps <= '0;
      end else begin
         taps <= {taps[DEPTH-2:0], d_i};
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q_o <= 1'b0;
      end else begin
         q_o <= taps[sel_i];
      end
   end
endmodule
`default_nettype wire

// ### logic/gbx_clk_div.sv
// Purpose: Edge clock divider by 2, 4 or 8
// Assumes: src_i is the edge clock sampled by the system clock
// Notes:   Hold forces the output low; release restarts the count on the next source edge
`default_nettype none
module gbx_clk_div
   import gbx_pkg::*;
(
   input  wire logic     core_clk_i,
   input  wire logic     resetn_i,
   input  wire logic     src_i,
   input  wire gbx_div_t div_sel_i,
   input  wire logic     hold_i,
   output logic          div_clk_o
);
   logic       src_prev;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic       src_rise;

   assign src_rise = src_i & ~src_prev;
   assign next_cnt = cnt + 3'h1;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         src_prev <= 1'b0;
      end else begin
         src_prev <= src_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt       <= 3'h0;
         div_clk_o <= 1'b0;
      end else if (hold_i) begin
         cnt       <= 3'h0;                                 // [R16]
         div_clk_o <= 1'b0;                                 // [R16]
      end else if (src_rise) begin
         cnt <= next_cnt;
         case (div_sel_i)
            GBX_DIV2: div_clk_o <= next_cnt[0];             // [R16]
            GBX_DIV4: div_clk_o <= next_cnt[1];             // [R16]
            default:  div_clk_o <= next_cnt[2];             // [R16]
         endcase
      end
   end
endmodule
`default_nettype wire

// ### tb/gbx_ddr_src.sv
// Purpose: DDR source model: strobe and pad data for both blocks of the pair
// Assumes: Bit slots of SLOT system cycles, strobe edge in mid-slot
// Notes:   Strobe rests low between frames; released data shows the inverse of the last bit
`default_nettype none
module gbx_ddr_src (
   input  wire logic       core_clk_i,
   input  wire logic       go_i,
   input  wire logic [7:0] pat_i,
   output logic            clk_o,
   output logic      [1:0] dat_o,
   output logic            busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SLOT = 6;
   int         cyc = 0;
   logic [7:0] pat = '0;
   logic       strobe = 1'b0;
   logic [1:0] dat = 2'b01;
   logic       busy = 1'b0;
   assign clk_o  = strobe;
   assign dat_o  = dat;
   assign busy_o = busy;
   // Even bits ride the rising strobe edge, odd bits the falling one; block 1 gets the inverse
   always @(posedge core_clk_i) begin
      if (!busy && go_i) begin
         busy <= 1'b1;
         pat <= pat_i;
         cyc <= 0;
      end else if (busy) begin
         cyc <= cyc + 1;
         if (cyc < 8 * SLOT && cyc % SLOT == 0)
            dat <= {~pat[cyc / SLOT], pat[cyc / SLOT]};
         if (cyc % SLOT == SLOT / 2)
            strobe <= ~strobe;
         if (cyc == 8 * SLOT) begin
            busy <= 1'b0;
            dat <= {pat[7], ~pat[7]};
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/test_ddr_input_register_gearbox.sv
// Purpose: Self-checking bench for the I/O cell pair
// Assumes: DDR source model on the pad side, APB master here
// Notes:   Latch, gear and divider pulses are compared as counted deltas
`default_nettype none
module test_ddr_input_register_gearbox
   import gbx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, go = 0;
   logic        use_tb = 1, mem = 1, wl = 0, dprev = 0, prs = 0;
   logic [11:0] pa = '0;
   logic [31:0] pwd = '0, prd;
   logic [1:0]  tpad = '0, cod = '0, ctr = '0, pad, sdat, sdr, dpos, dneg, pod, ptc, byp, ick;
   logic [7:0]  pat = '0;
   logic        prdy, perr, sclk, sbusy, sdi, dsc, pol, lat, gv, wlo, dvo;
   gbx_gear_t   gear;
   int          err_count = 0, n_checks = 0, cyc = 0, nlat = 0, ngv = 0, ndiv = 0;
   always #50 clk = ~clk;
   assign pad = use_tb ? tpad : sdat;
   gbx_io_cell i_dut (.core_clk_i(clk), .resetn_i(rstn), .paddr_i(pa), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
      .pslverr_o(perr), .pad_in_data_i(pad), .core_out_data_i(cod), .core_tristate_i(ctr),
      .pad_out_data_o(pod), .pad_tristate_ctl_o(ptc), .comb_input_bypass_o(byp),
      .input_as_clock_o(ick), .strobe_delay_in_o(sdi), .edge_clk_i(mem ? 1'b0 : sclk),
      .strobe_clk_i(mem ? sclk : 1'b0), .wl_clk_i(wl), .delayed_strobe_clk_o(dsc),
      .sync_clk_polarity_o(pol), .sync_transfer_latch_o(lat), .sdr_data_o(sdr),
      .ddr_pos_o(dpos), .ddr_neg_o(dneg), .gear_o(gear), .gear_valid_o(gv),
      .wl_clk_o(wlo), .div_clk_o(dvo));
   gbx_ddr_src i_src (.core_clk_i(clk), .go_i(go), .pat_i(pat), .clk_o(sclk),
      .dat_o(sdat), .busy_o(sbusy));
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      n_checks++;
      if (g !== x) begin
         err_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] x, input logic xe);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      if (!w) chk(prd, x, "read");
      chk(32'(perr), 32'(xe), "slverr");
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic frame(input logic [7:0] p);
      @(posedge clk);
      go <= 1'b1;
      pat <= p;
      @(posedge clk);
      go <= 1'b0;
      do @(posedge clk); while (sbusy === 1'b1);
      repeat (12) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (lat === 1'b1) nlat <= nlat + 1;
      if (gv === 1'b1) ngv <= ngv + 1;
      if (dvo === 1'b1 && dprev === 1'b0) ndiv <= ndiv + 1;
      dprev <= dvo;
      prs <= mem ? sclk : 1'b0;
      if (rstn === 1'b1) chk(32'(dsc), 32'(prs), "strobe");
      if (cyc == 30000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      int n;
      repeat (20) @(posedge clk);
      chk(32'(ptc), 32'h3, "tristate reset");
      rstn <= 1'b1;
      acc(0, GBX_OFF_CTRL, 0, GBX_CTRL_RESET, 0);
      acc(0, GBX_OFF_DELAY, 0, GBX_DELAY_RESET, 0);
      cod <= 2'b10;
      ctr <= 2'b01;
      @(posedge clk);
      #1;
      chk(32'(pod), 32'h2, "pad data");
      chk(32'(ptc), 32'h1, "tristate");
      $display("test pads done");
      acc(1, GBX_OFF_CTRL, 32'hffff_ffff, 0, 0);
      acc(0, GBX_OFF_CTRL, 0, 32'h1fc, 0);
      chk(32'(pol), 32'h1, "polarity");
      acc(1, GBX_OFF_STAT, 32'hffff_ffff, 0, 0);
      acc(1, 12'h00c, 32'h1, 0, 1);
      acc(0, 12'h00c, 0, 0, 1);
      for (int m = 0; m < 3; m++) begin
         acc(1, GBX_OFF_CTRL, m, 0, 0);
         acc(0, GBX_OFF_CTRL, 0, m, 0);
      end
      $display("test registers done");
      acc(1, GBX_OFF_DELAY, 32'h5, 0, 0);
      for (int i = 0; i < 3; i++) begin
         acc(1, GBX_OFF_CTRL, i == 0 ? 32'h0 : (i == 1 ? 32'h18 : 32'h8), 0, 0);
         repeat (16) @(posedge clk);
         tpad <= ~tpad;
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (sdr === ~tpad && n < 40);
         chk(n, i == 0 ? 1 : (i == 1 ? 8 : 11), "sdr latency");
         chk(32'(sdr), 32'(tpad), "sdr data");
         chk({byp, ick, 27'h0, sdi}, {tpad, tpad, 27'h0, tpad[0]}, "bypass");
      end
      $display("test sdr done");
      for (int i = 0; i < 2; i++) begin
         acc(1, GBX_OFF_DELAY, i ? 32'h8500 : 32'h0, 0, 0);
         repeat (140) @(posedge clk);
         wl <= 1'b1;
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (wlo === 1'(i) && n < 200);
         chk(n, i ? 8 : 3, "wl delay");
         chk(32'(wlo), i ? 0 : 1, "wl level");
         wl <= 1'b0;
      end
      $display("test write level done");
      use_tb <= 1'b0;
      for (int p = 0; p < 2; p++) begin
         acc(1, GBX_OFF_CTRL, p ? 32'h101 : 32'h1, 0, 0);
         n = nlat;
         frame(8'h96);
         chk(32'(dpos), p ? 32'h1 : 32'h2, "ddr pos");
         chk(32'(dneg), p ? 32'h2 : 32'h1, "ddr neg");
         chk(nlat - n, 4, "latches");
      end
      $display("test ddr done");
      acc(1, GBX_OFF_CTRL, 32'h2, 0, 0);
      n = ngv;
      frame(8'h96);
      chk(32'(gear), 32'h9, "gear data");
      chk(ngv - n, 2, "gear words");
      acc(0, GBX_OFF_STAT, 0, 32'h133a, 0);
      $display("test gearbox done");
      mem <= 1'b0;
      for (int d = 0; d < 3; d++) begin
         acc(1, GBX_OFF_CTRL, 32'h85 | (d << 5), 0, 0);
         repeat (2) @(posedge clk);
         chk(32'(dvo), 0, "div hold");
         acc(1, GBX_OFF_CTRL, 32'h5 | (d << 5), 0, 0);
         n = ndiv;
         frame(8'h96);
         frame(8'h96);
         chk(ndiv - n, 4 >> d, "div edges");
         chk({dpos, dneg}, 32'h9, "generic ddr");
      end
      $display("test divider done");
      close_out();
   end
endmodule
`default_nettype wire
